// file: logic/jis_sync2.sv
`timescale 1ns/1ps

module jis_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,   // destination clock
    input  wire logic         rstB,  // synchronous reset, active low
    input  wire logic [W-1:0] d,     // level from the other domain
    output logic      [W-1:0] q      // synchronised level
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] hold;
    } jis_sync_st_t;

    jis_sync_st_t st;
    jis_sync_st_t next_st;

    always_comb
    begin
        next_st.meta = d;
        next_st.hold = st.meta;
        if (!rstB)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk)
    begin
        st <= next_st;
    end

    assign q = st.hold;

endmodule : jis_sync2

// file: logic/jis_tap.sv
`timescale 1ns/1ps

// What this block does
// - On this size without scan cells, the external-test and sample instructions select the one-bit bypass register.
// - The identification word is 32 bits: version 4, part number 16, manufacturer 11, then one fixed bit.
// - Each identification field is written most significant bit leftmost.
// - Bit zero of the identification word always reads as one.
// - With the security bit programmed, a link read of the stored configuration returns REFUSED_WORD; the cfgData port still shows the store.
// - The security bit and all configuration are cleared only by a whole-device erase.
// - The instruction register is ten bits long.
// - The bypass instruction puts a single-bit register between data-in and data-out.
// - The identification instruction puts the identification register between data-in and data-out.
module jis_tap (
    input  wire logic                       clk,      // system clock, 40 MHz
    input  wire logic                       rst_b,    // synchronous reset, active low
    input  wire logic                       tck,      // test clock from the controller
    input  wire logic                       tms,      // test mode select
    input  wire logic                       tdi,      // serial data in
    output logic                            tdo,      // serial data out
    output logic                            tdoOeB,   // data-out enable, low while driving
    input  wire logic [jis_pkg::CFG_AW-1:0] cfgAddr,  // device logic config word select
    output logic      [jis_pkg::CFG_DW-1:0] cfgData,  // selected config word, registered
    output logic                            secured   // security bit state, registered
);
    import jis_pkg::*;

    // ************************************************************
    // crossings
    // ************************************************************
    logic tckRstB;
    logic reqSync;
    logic ackSync;

    jis_tck_st_t t;
    jis_tck_st_t next_t;
    jis_tdo_st_t o;
    jis_tdo_st_t next_o;
    jis_clk_st_t c;
    jis_clk_st_t next_c;

    // reset reaches the test-clock side only while tck runs
    jis_sync2 #(.W(1)) uRstSync (
        .clk  (tck),
        .rstB (1'b1),
        .d    (rst_b),
        .q    (tckRstB)
    );

    jis_sync2 #(.W(1)) uReqSync (
        .clk  (clk),
        .rstB (rst_b),
        .d    (t.reqTgl),
        .q    (reqSync)
    );

    jis_sync2 #(.W(1)) uAckSync (
        .clk  (tck),
        .rstB (tckRstB),
        .d    (c.ackTgl),
        .q    (ackSync)
    );

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic jis_tap_t tapNext(input jis_tap_t s, input logic m);
        jis_tap_t n;
        n = s;
        case (s)
            TAP_RESET:    n = m ? TAP_RESET    : TAP_IDLE;
            TAP_IDLE:     n = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_DR:   n = m ? TAP_SEL_IR   : TAP_CAP_DR;
            TAP_CAP_DR:   n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: n = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: n = m ? TAP_UPD_DR   : TAP_PAUSE_DR;
            TAP_PAUSE_DR: n = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: n = m ? TAP_UPD_DR   : TAP_SHIFT_DR;
            TAP_UPD_DR:   n = m ? TAP_SEL_DR   : TAP_IDLE;
            TAP_SEL_IR:   n = m ? TAP_RESET    : TAP_CAP_IR;
            TAP_CAP_IR:   n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: n = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: n = m ? TAP_UPD_IR   : TAP_PAUSE_IR;
            TAP_PAUSE_IR: n = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: n = m ? TAP_UPD_IR   : TAP_SHIFT_IR;
            TAP_UPD_IR:   n = m ? TAP_SEL_DR   : TAP_IDLE;
            default:      n = TAP_RESET;
        endcase
        return n;
    endfunction : tapNext

    function automatic jis_sel_t drSelect(input logic [IR_LEN-1:0] ins);
        jis_sel_t s;
        s = SEL_BYP;
        if (ins == INS_IDCODE)
        begin
            s = SEL_ID;
        end
        else if (ins == INS_ISP_ERASE || ins == INS_ISP_PROG ||
                 ins == INS_ISP_READ || ins == INS_ISP_SECURE)
        begin
            s = SEL_ISP;
        end
        else if (ins == INS_EXTEST || ins == INS_SAMPLE)
        begin
            s = SEL_BYP;
        end
        else
        begin
            s = SEL_BYP;
        end
        return s;
    endfunction : drSelect

    function automatic jis_op_t opOf(input logic [IR_LEN-1:0] ins);
        jis_op_t p;
        p = OP_READ;
        if (ins == INS_ISP_ERASE)
        begin
            p = OP_ERASE;
        end
        else if (ins == INS_ISP_PROG)
        begin
            p = OP_WRITE;
        end
        else if (ins == INS_ISP_SECURE)
        begin
            p = OP_SECURE;
        end
        return p;
    endfunction : opOf

    // ************************************************************
    // test-clock side: controller, instruction and data paths
    // ************************************************************
    jis_sel_t sel;
    logic     busy;

    assign sel  = drSelect(t.ir);
    assign busy = t.reqTgl != ackSync;

    always_comb
    begin
        next_t     = t;
        next_t.tap = tapNext(t.tap, tms);
        case (t.tap)
            TAP_RESET:
            begin
                next_t.ir = INS_IDCODE;
            end
            TAP_CAP_IR:
            begin
                next_t.irShift = IR_CAPTURE;
            end
            TAP_SHIFT_IR:
            begin
                next_t.irShift = {tdi, t.irShift[IR_LEN-1:1]};
            end
            TAP_UPD_IR:
            begin
                next_t.ir = t.irShift;
            end
            TAP_CAP_DR:
            begin
                case (sel)
                    SEL_ID:  next_t.dr = ID_WORD;
                    SEL_ISP: next_t.dr[ISP_LEN-1:0] = {t.req.addr, t.rdHold};
                    default: next_t.dr[0] = 1'b0;
                endcase
            end
            TAP_SHIFT_DR:
            begin
                case (sel)
                    SEL_ID:  next_t.dr = {tdi, t.dr[ID_LEN-1:1]};
                    SEL_ISP: next_t.dr[ISP_LEN-1:0] = {tdi, t.dr[ISP_LEN-1:1]};
                    default: next_t.dr[0] = tdi;
                endcase
            end
            TAP_UPD_DR:
            begin
                // a new command while one is still in flight is dropped
                if (sel == SEL_ISP && !busy)
                begin
                    next_t.req.op   = opOf(t.ir);
                    next_t.req.addr = t.dr[ISP_LEN-1:CFG_DW];
                    next_t.req.data = t.dr[CFG_DW-1:0];
                    next_t.reqTgl   = ~t.reqTgl;
                end
            end
            default:
            begin
                next_t.tap = tapNext(t.tap, tms);
            end
        endcase
        if (ackSync != t.ackSeen)
        begin
            next_t.ackSeen = ackSync;
            next_t.rdHold  = c.rsp;
        end
        if (!tckRstB)
        begin
            next_t         = '0;
            next_t.tap     = TAP_RESET;
            next_t.ir      = INS_IDCODE;
            next_t.irShift = IR_CAPTURE;
            next_t.req.op  = OP_READ;
        end
    end

    always_ff @(posedge tck)
    begin
        t <= next_t;
    end

    // ************************************************************
    // data out changes on the falling test-clock edge
    // ************************************************************
    always_comb
    begin
        next_o.bit0 = 1'b0;
        next_o.oeB  = 1'b1;
        if (t.tap == TAP_SHIFT_IR)
        begin
            next_o.bit0 = t.irShift[0];
            next_o.oeB  = 1'b0;
        end
        else if (t.tap == TAP_SHIFT_DR)
        begin
            next_o.bit0 = t.dr[0];
            next_o.oeB  = 1'b0;
        end
        if (!tckRstB)
        begin
            next_o.bit0 = 1'b0;
            next_o.oeB  = 1'b1;
        end
    end

    always_ff @(negedge tck)
    begin
        o <= next_o;
    end

    assign tdo    = o.bit0;
    assign tdoOeB = o.oeB;

    // ************************************************************
    // system-clock side: configuration store and security bit
    // ************************************************************
    // request fields are stable from the toggle until its acknowledge
    always_comb
    begin
        next_c         = c;
        next_c.cfgData = c.cfg[cfgAddr];
        if (reqSync != c.reqSeen)
        begin
            next_c.reqSeen = reqSync;
            next_c.ackTgl  = ~c.ackTgl;
            case (t.req.op)
                OP_ERASE:
                begin
                    for (int i = 0; i < CFG_WORDS; i++)
                    begin
                        next_c.cfg[i] = CFG_ERASED;
                    end
                    next_c.secured = 1'b0;
                end
                OP_WRITE:
                begin
                    next_c.cfg[t.req.addr] = t.req.data;
                end
                OP_SECURE:
                begin
                    next_c.secured = 1'b1;
                end
                default:
                begin
                    next_c.rsp = c.secured ? REFUSED_WORD : c.cfg[t.req.addr];
                end
            endcase
        end
        // the store is non-volatile: reset leaves it and the security bit alone
        if (!rst_b)
        begin
            next_c.reqSeen = 1'b0;
            next_c.ackTgl  = 1'b0;
            next_c.rsp     = RSP_RESET;
            next_c.cfgData = RSP_RESET;
        end
    end

    always_ff @(posedge clk)
    begin
        c <= next_c;
    end

    assign cfgData = c.cfgData;
    assign secured = c.secured;

endmodule : jis_tap

// file: shared/jis_pkg.sv
package jis_pkg;

    // ************************************************************
    // register lengths
    // ************************************************************
    localparam int IR_LEN    = 10;
    localparam int ID_LEN    = 32;
    localparam int BYP_LEN   = 1;
    localparam int BSR_LEN   = 1;
    localparam int ISP_LEN   = 20;
    localparam int CFG_AW    = 4;
    localparam int CFG_DW    = 16;
    localparam int CFG_WORDS = 16;

    // ************************************************************
    // identification word (version, part and maker values arbitrary; fixed bit is one)
    // ************************************************************
    localparam logic [3:0]  ID_VERSION = 4'h3;
    localparam logic [15:0] ID_PART    = 16'hA5C3;
    localparam logic [10:0] ID_MAKER   = 11'h2B5;
    localparam logic        ID_FIXED   = 1'b1;
    localparam logic [31:0] ID_WORD    = {ID_VERSION, ID_PART, ID_MAKER, ID_FIXED};

    // ************************************************************
    // instruction codes and capture pattern
    // ************************************************************
    localparam logic [9:0] IR_CAPTURE     = 10'h001;
    localparam logic [9:0] INS_EXTEST     = 10'h000;
    localparam logic [9:0] INS_SAMPLE     = 10'h055;
    localparam logic [9:0] INS_IDCODE     = 10'h059;
    localparam logic [9:0] INS_BYPASS     = 10'h3FF;
    localparam logic [9:0] INS_ISP_ERASE  = 10'h0F2;
    localparam logic [9:0] INS_ISP_PROG   = 10'h0F4;
    localparam logic [9:0] INS_ISP_READ   = 10'h0F5;
    localparam logic [9:0] INS_ISP_SECURE = 10'h0F9;

    // ************************************************************
    // values after erase, after reset and for a refused read
    // ************************************************************
    localparam logic [15:0] CFG_ERASED   = 16'hFFFF;
    localparam logic [15:0] RSP_RESET    = 16'h0000;
    localparam logic [15:0] REFUSED_WORD = 16'h0000;

    typedef enum logic [15:0] {
        TAP_RESET    = 16'h0001,
        TAP_IDLE     = 16'h0002,
        TAP_SEL_DR   = 16'h0004,
        TAP_CAP_DR   = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR   = 16'h0100,
        TAP_SEL_IR   = 16'h0200,
        TAP_CAP_IR   = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR   = 16'h8000
    } jis_tap_t;

    typedef enum logic [1:0] {
        OP_ERASE  = 2'h0,
        OP_WRITE  = 2'h1,
        OP_READ   = 2'h2,
        OP_SECURE = 2'h3
    } jis_op_t;

    typedef enum logic [1:0] {
        SEL_BYP = 2'h0,
        SEL_ID  = 2'h1,
        SEL_ISP = 2'h2
    } jis_sel_t;

    typedef struct packed {
        jis_op_t            op;
        logic [CFG_AW-1:0]  addr;
        logic [CFG_DW-1:0]  data;
    } jis_req_t;

    typedef struct packed {
        jis_tap_t           tap;
        logic [IR_LEN-1:0]  ir;
        logic [IR_LEN-1:0]  irShift;
        logic [ID_LEN-1:0]  dr;
        jis_req_t           req;
        logic               reqTgl;
        logic               ackSeen;
        logic [CFG_DW-1:0]  rdHold;
    } jis_tck_st_t;

    typedef struct packed {
        logic               bit0;
        logic               oeB;
    } jis_tdo_st_t;

    typedef struct packed {
        logic [CFG_WORDS-1:0][CFG_DW-1:0] cfg;
        logic               secured;
        logic               reqSeen;
        logic               ackTgl;
        logic [CFG_DW-1:0]  rsp;
        logic [CFG_DW-1:0]  cfgData;
    } jis_clk_st_t;

endpackage : jis_pkg

// file: sim/jis_host.sv
`timescale 1ns/1ps

module jis_host (
    output logic      tck,    // test clock, still between frames
    output logic      tms,    // mode select
    output logic      tdi,    // serial data to device
    input  wire logic tdo,    // serial data from device
    input  wire logic tdoOeB  // device out enable, low drives
);
    logic seen;
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // inputs move with tck low, tdo taken at the rising edge
    // uneven halves keep rising tck edges off the clk grid; falling edges land on it
    task automatic tick(input logic m, input logic d);
        tms = m;
        tdi = d;
        #61.3;
        tck = 1'b1;
        seen = tdoOeB ? ~tdo : tdo; // released line reads inverted
        #63.7;
        tck = 1'b0;
    endtask : tick

    task automatic tlr;
        repeat (5) tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
    endtask : tlr

    // from idle: n bits, least significant first, back to idle via update
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        int i;
        dout = 32'h0;
        repeat (4) tick(1'b0, ~tdi);
        tick(1'b1, ~tdi);
        if (ir)
            tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
        tick(1'b0, ~tdi);
        for (i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i]);
            dout[i] = seen;
        end
        tick(1'b1, ~tdi);
        tick(1'b0, ~tdi);
    endtask : scan
endmodule : jis_host

// file: sim/jis_tap_properties.sv
`timescale 1ns/1ps

module jis_tap_properties
    import jis_pkg::*;
(
    input wire logic                       clk,     // system clock
    input wire logic                       rst_b,   // sync reset, active low
    input wire logic                       tck,     // test clock
    input wire logic                       tms,     // mode select
    input wire logic                       tdi,     // serial in
    input wire logic                       tdo,     // serial out
    input wire logic                       tdoOeB,  // out enable, low drives
    input wire logic [jis_pkg::CFG_AW-1:0] cfgAddr, // word select
    input wire logic [jis_pkg::CFG_DW-1:0] cfgData, // selected word
    input wire logic                       secured  // security bit
);
    // ************
    // calm detector
    // ************
    // store only moves through link ops, so 15 clk without a tck edge means settled
    logic       tckQ;
    logic [3:0] calm;
    logic       armed;
    logic       calmNow;
    assign calmNow = (calm == 4'hF);
    always_ff @(posedge clk)
    begin
        tckQ  <= tck;
        calm  <= (tck != tckQ) ? 4'h0 : (calmNow ? calm : calm + 4'h1);
        armed <= armed | (secured == 1'b0);
    end

    sequence tmsHold;
        tms [*5];
    endsequence

    idle_tdo_low_a: assert property (@(posedge tck) disable iff (!rst_b) tdoOeB |-> !tdo)
        else $error("tdo high while not driven");
    tap_reset_oe_a: assert property (@(posedge tck) disable iff (!rst_b) tmsHold |=> tdoOeB)
        else $error("output still enabled after test reset");
    tms_exit_oe_a: assert property (@(posedge tck) disable iff (!rst_b) tms |=> tdoOeB)
        else $error("output enabled outside a shift state");
    out_fall_only_a: assert property (@(posedge clk) disable iff (!rst_b)
        (tck && $past(tck) && !tdoOeB) |-> $stable(tdo))
        else $error("tdo moved while tck high");
    secure_fall_erase_a: assert property (@(posedge clk) disable iff (!rst_b)
        $fell(secured) |-> ##[0:2] (cfgData == CFG_ERASED))
        else $error("security cleared without erased store");
    secure_calm_a: assert property (@(posedge clk) disable iff (!rst_b)
        (armed && calmNow) |-> $stable(secured))
        else $error("security bit moved with link idle");
    cfg_calm_a: assert property (@(posedge clk) disable iff (!rst_b)
        (armed && calmNow && $past(rst_b) && $stable(cfgAddr)) |=> $stable(cfgData))
        else $error("config word moved with link idle");
    secure_keep_data_a: assert property (@(posedge clk) disable iff (!rst_b)
        (armed && $rose(secured) && $stable(cfgAddr)) |=> $stable(cfgData))
        else $error("securing altered the store");
endmodule : jis_tap_properties

bind jis_tap jis_tap_properties chk (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOeB(tdoOeB), .cfgAddr(cfgAddr), .cfgData(cfgData), .secured(secured));

// file: sim/tb.sv
`timescale 1ns/1ps

module tb;
    import jis_pkg::*;
    localparam logic [31:0] PAT     = 32'h9E375AC1;
    // one-bit path: captured zero first, then the pattern one bit late
    localparam logic [31:0] BYP_OUT = {PAT[30:0], 1'b0};

    typedef struct packed {
        logic [9:0]  code;
        logic [31:0] exp;
    } jis_row_t;

    logic                 clk;
    logic                 rst_b;
    logic                 tck;
    logic                 tms;
    logic                 tdi;
    logic                 tdo;
    logic                 tdoOeB;
    logic                 secured;
    logic [CFG_AW-1:0]    cfgAddr;
    logic [CFG_DW-1:0]    cfgData;
    logic [31:0]          got;
    int                   bad_count;
    int                   checked;
    jis_row_t             rows [5] = '{'{INS_EXTEST, BYP_OUT}, '{INS_SAMPLE, BYP_OUT}, '{INS_BYPASS, BYP_OUT},
                                       '{10'h123, BYP_OUT}, '{INS_IDCODE, ID_WORD}};

    jis_tap uut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeB(tdoOeB),
        .cfgAddr(cfgAddr), .cfgData(cfgData), .secured(secured));
    jis_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeB(tdoOeB));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ************
    // helpers
    // ************
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // tck must run while reset is low so the link side sees it
    task automatic do_reset;
        rst_b <= 1'b0;
        fork
            begin
                repeat (12) @(posedge clk);
                rst_b <= 1'b1;
            end
            host.tlr();
        join
        host.tlr();
    endtask : do_reset

    // op lands after update; 20 clk covers the way in, the ack returns on later tck edges
    task automatic isp(input logic [9:0] code, input logic [19:0] dr);
        host.scan(1'b1, IR_LEN, {22'h0, code}, got);
        host.scan(1'b0, ISP_LEN, {12'h0, dr}, got);
        repeat (20) @(posedge clk);
    endtask : isp

    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        end_sim();
    end

    // ************
    // sequence
    // ************
    initial
    begin
        bad_count = 0;
        checked = 0;
        rst_b = 1'b0;
        cfgAddr = 4'h0;
        do_reset();
        host.scan(1'b0, ID_LEN, PAT, got);
        check("fixed bit", 32'(got[0]), 32'h1);
        check("maker", 32'(got[11:1]), 32'(ID_MAKER));
        check("part", 32'(got[27:12]), 32'(ID_PART));
        check("version", 32'(got[31:28]), 32'(ID_VERSION));
        foreach (rows[k])
        begin
            host.scan(1'b1, IR_LEN, {22'h0, rows[k].code}, got);
            check("ir capture", 32'(got[9:0]), 32'(IR_CAPTURE));
            host.scan(1'b0, ID_LEN, PAT, got);
            check("dr out", got, rows[k].exp);
        end
        isp(INS_ISP_ERASE, 20'h0);
        @(posedge clk);
        cfgAddr <= 4'h5;
        repeat (3) @(posedge clk);
        check("secured", 32'(secured), 32'h0);
        check("erased", 32'(cfgData), 32'(CFG_ERASED));
        isp(INS_ISP_PROG, {4'h5, 16'h1234});
        check("written", 32'(cfgData), 32'h1234);
        isp(INS_ISP_READ, {4'h5, 16'h0});
        host.scan(1'b0, ISP_LEN, {12'h0, 4'h5, 16'h0}, got);
        check("readback", 32'(got[19:0]), 32'h51234);
        repeat (20) @(posedge clk);
        isp(INS_ISP_SECURE, 20'h0);
        check("secured", 32'(secured), 32'h1);
        isp(INS_ISP_READ, {4'h5, 16'h0});
        host.scan(1'b0, ISP_LEN, {12'h0, 4'h5, 16'h0}, got);
        check("refused read", 32'(got[19:0]), {12'h0, 4'h5, REFUSED_WORD});
        check("store kept", 32'(cfgData), 32'h1234);
        repeat (20) @(posedge clk);
        do_reset();
        repeat (3) @(posedge clk);
        check("secured after reset", 32'(secured), 32'h1);
        check("store after reset", 32'(cfgData), 32'h1234);
        isp(INS_ISP_ERASE, 20'h0);
        check("secured after erase", 32'(secured), 32'h0);
        check("erased again", 32'(cfgData), 32'(CFG_ERASED));
        end_sim();
    end
endmodule : tb
